// *** include/scfc_pkg.sv ***
// shared constants for the serial command flow-control block
// assumes a 40 MHz system clock and a byte-wide uart beside the block
package scfc_pkg;

  // ****************************************************************
  // packet layout and command codes
  // ****************************************************************
  localparam logic [7:0] SCFC_HDR          = 8'h10; // packet header byte
  localparam logic [7:0] SCFC_CMD_MODE     = 8'hF1; // mode-entry command code
  localparam logic [7:0] SCFC_PH_MODE      = 8'hFF; // param_high_byte of mode entry
  localparam logic [7:0] SCFC_PL_SPECIAL2  = 8'h00; // param_low_byte, second special mode
  localparam logic [7:0] SCFC_PL_SERVICE   = 8'hFF; // param_low_byte, service mode
  localparam logic [7:0] SCFC_RESP_ZERO    = 8'h00; // response parameter for mode entry
  localparam logic [2:0] SCFC_LAST_BYTE    = 3'h4;  // index of the fifth packet byte
  localparam logic [2:0] SCFC_PKT_BYTES    = 3'h5;  // bytes in one packet

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int SCFC_CLK_HZ          = 40_000_000;
  localparam int SCFC_HOLD_MS         = 1000; // longest response pause
  localparam int SCFC_HOLD_CYCLES     = SCFC_CLK_HZ / 1000 * SCFC_HOLD_MS;
  localparam int SCFC_MODE_EXEC_MS    = 100;  // longest mode-entry execution
  localparam int SCFC_MODE_EXEC_CYCLES = SCFC_CLK_HZ / 1000 * SCFC_MODE_EXEC_MS;
  localparam int SCFC_HOLD_W          = 26;   // width of the hold counter

  // ****************************************************************
  // command-side states
  // ****************************************************************
  typedef enum logic [3:0] {
    SCFC_IDLE  = 4'h1,
    SCFC_READY = 4'h2,
    SCFC_EXEC  = 4'h4,
    SCFC_RESP  = 4'h8
  } scfc_state_t;

endpackage

// *** include/scfc_if.sv ***
// carrier between the command side and the response pacer
// assumes both ends sit on the same system clock
`timescale 1ns/1ps
`default_nettype none
interface scfc_if;
  logic        load;     // one-cycle start of a response
  logic [39:0] pkt;      // response bytes, first byte in the top bits
  logic        rts;      // synchronised request-to-send level
  logic        busy;     // response in progress
  logic        aborted;  // one-cycle pulse, response abandoned
  logic        tx_valid; // byte offered to the uart
  logic [7:0]  tx_data;
  logic        tx_ready; // uart takes the byte

  modport cmd   (output load, pkt, rts, tx_ready, input busy, aborted, tx_valid, tx_data);
  modport pacer (input load, pkt, rts, tx_ready, output busy, aborted, tx_valid, tx_data);
endinterface
`default_nettype wire

// *** rtl/scfc_tx_pacer.sv ***
// response pacer: streams a five-byte response, pauses on rts low
// assumes the uart behind tx_ready holds at most three queued bytes
`timescale 1ns/1ps
`default_nettype none
module scfc_tx_pacer
  import scfc_pkg::*;
#(
  parameter int HOLD_CYCLES = SCFC_HOLD_CYCLES
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // link to command side
  scfc_if.pacer    bus
);

  typedef struct packed {
    logic                   active;
    logic [2:0]             idx;
    logic                   valid;
    logic [7:0]             data;
    logic [SCFC_HOLD_W-1:0] hold;
    logic                   aborted;
  } scfc_pacer_t;

  scfc_pacer_t s_q, s_d;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d         = s_q;
    s_d.aborted = 1'b0;
    if (s_q.valid && bus.tx_ready) begin
      s_d.valid = 1'b0;
      s_d.idx   = s_q.idx + 3'h1;
    end
    if (bus.load) begin
      s_d.active = 1'b1;
      s_d.idx    = 3'h0;
      s_d.hold   = '0;
      s_d.valid  = 1'b1;
      s_d.data   = bus.pkt[39:32];
    end else if (s_q.active && !s_d.valid) begin
      if (s_d.idx == SCFC_PKT_BYTES) begin
        s_d.active = 1'b0;
      end else if (bus.rts) begin
        // resume where the pause stopped hold timer clears
        s_d.hold  = '0;
        s_d.valid = 1'b1;
        s_d.data  = bus.pkt[8'(39 - 8 * s_d.idx) -: 8];
      end else if (s_q.hold == SCFC_HOLD_W'(HOLD_CYCLES - 1)) begin
        // pause too long: drop the rest of the response
        s_d.active  = 1'b0;
        s_d.aborted = 1'b1;
      end else begin
        // only the byte already offered goes out while paused
        s_d.hold = s_q.hold + SCFC_HOLD_W'(1);
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs to command side
  assign bus.busy     = s_q.active;
  assign bus.aborted  = s_q.aborted;
  assign bus.tx_valid = s_q.valid;
  assign bus.tx_data  = s_q.data;

endmodule
`default_nettype wire

// *** rtl/scfc_top.sv ***
// serial command flow control: packet intake, cts handshake, mode entry
// assumes a byte uart on i_sys_clk; rts arrives from the pin unsynchronised
// and the id switches are quasi-static, so a plain two-flop stage is enough
//
// Operation
// - header 10, code F1, params FF 00 requests the second special mode.
// - header 10, code F1, params FF FF requests service mode.
// - both mode-entry commands are taken whatever the device id field holds.
// - a mode-entry command is answered at once with zero parameter bytes.
// - a mode-entry command completes within 100 ms.
// - bytes received while rts is low are discarded.
// - after rts rises the device raises cts within the cts_assert_delay.
// - cts drops on a received packet other than mode entry and stays low during execution.
// - when execution ends cts rises together with the start of the response.
// - command_turnaround_time depends on the command type.
// - on rts low the response pauses after at most three queued bytes.
// - rts low for 1000 ms abandons the rest of the response.
// - rts back within 1000 ms resumes the response where it stopped.
`timescale 1ns/1ps
`default_nettype none
module scfc_top
  import scfc_pkg::*;
#(
  parameter int HOLD_CYCLES = SCFC_HOLD_CYCLES
) (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  // handshake pins
  input  wire logic       i_rts,
  output logic            o_cts,
  // received bytes from the uart
  input  wire logic       i_rx_valid,
  input  wire logic [7:0] i_rx_data,
  // transmit bytes to the uart
  output logic            o_tx_valid,
  output logic [7:0]      o_tx_data,
  input  wire logic       i_tx_ready,
  // configured identifier
  input  wire logic [7:0] i_device_id,
  // ordinary commands to the executing logic
  output logic            o_cmd_valid,
  output logic [7:0]      o_cmd_code,
  output logic [7:0]      o_cmd_param_high_byte,
  output logic [7:0]      o_cmd_param_low_byte,
  input  wire logic       i_exec_done,
  input  wire logic [7:0] i_resp_param_high_byte,
  input  wire logic [7:0] i_resp_param_low_byte,
  // mode entry and status
  output logic            o_enter_special2,
  output logic            o_enter_service,
  output logic            o_resp_aborted
);

  // ****************************************************************
  // state
  // ****************************************************************
  // all state outside the pacer, registered in one place
  typedef struct packed {
    logic        rts_s1;
    logic        rts_s2;
    logic [7:0]  dev_s1;
    logic [7:0]  dev_s2;
    scfc_state_t st;
    logic [2:0]  cnt;
    logic [7:0]  id;
    logic [7:0]  cmd;
    logic [7:0]  param_high;
    logic [7:0]  param_low;
    logic        cts;
    logic        load;
    logic [39:0] pkt;
    logic        cmd_valid;
    logic        special2;
    logic        service;
    logic        aborted;
  } scfc_top_t;

  scfc_top_t s_q, s_d;
  scfc_if    link ();
  logic      rx_take;
  logic      is_mode;

  // ****************************************************************
  // response pacer
  // ****************************************************************
  scfc_tx_pacer #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_pacer (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .bus       (link.pacer)
  );

  // ****************************************************************
  // link and intake wiring
  // ****************************************************************

  // link wiring
  assign link.load     = s_q.load;
  assign link.pkt      = s_q.pkt;
  assign link.rts      = s_q.rts_s2;
  assign link.tx_ready = i_tx_ready;

  // bytes only count while rts is high and a packet is awaited
  assign rx_take = i_rx_valid && s_q.rts_s2 && (s_q.st == SCFC_READY);
  // mode entry ignores the id byte
  assign is_mode = (s_q.cmd == SCFC_CMD_MODE) && (s_q.param_high == SCFC_PH_MODE)
                && ((i_rx_data == SCFC_PL_SPECIAL2) || (i_rx_data == SCFC_PL_SERVICE));

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d           = s_q;
    s_d.rts_s1    = i_rts;
    s_d.rts_s2    = s_q.rts_s1;
    // id switches are pins: only the second stage is compared
    s_d.dev_s1    = i_device_id;
    s_d.dev_s2    = s_q.dev_s1;
    s_d.load      = 1'b0;
    s_d.cmd_valid = 1'b0;
    s_d.special2  = 1'b0;
    s_d.service   = 1'b0;
    s_d.aborted   = link.aborted;
    unique case (s_q.st)
      SCFC_IDLE: begin
        s_d.cnt = 3'h0;
        if (s_q.rts_s2) begin
          s_d.cts = 1'b1; // host present, open the link
          s_d.st  = SCFC_READY;
        end
      end
      SCFC_READY: begin
        if (!s_q.rts_s2) begin
          s_d.cts = 1'b0;
          s_d.st  = SCFC_IDLE;
        end else if (rx_take) begin
          s_d.cnt = s_q.cnt + 3'h1;
          unique case (s_q.cnt)
            3'h0: if (i_rx_data != SCFC_HDR) s_d.cnt = 3'h0; // resync on header
            3'h1: s_d.id  = i_rx_data;
            3'h2: s_d.cmd = i_rx_data;
            3'h3: s_d.param_high = i_rx_data;
            default: begin
              s_d.cnt = 3'h0;
              s_d.cts = 1'b0; // packet in, hold off the host
              if (is_mode) begin
                // answer at once with zero parameters
                s_d.special2 = (i_rx_data == SCFC_PL_SPECIAL2);
                s_d.service  = (i_rx_data == SCFC_PL_SERVICE);
                s_d.pkt      = {SCFC_HDR, s_q.id, s_q.cmd, SCFC_RESP_ZERO, SCFC_RESP_ZERO};
                s_d.load     = 1'b1;
                s_d.cts      = 1'b1;
                s_d.st       = SCFC_RESP;
              end else if (s_q.id == s_q.dev_s2) begin
                s_d.cmd_valid = 1'b1;
                s_d.param_low = i_rx_data;
                s_d.st        = SCFC_EXEC;
              end else begin
                s_d.st = SCFC_IDLE; // not ours: reopen without answer
              end
            end
          endcase
          if (s_q.cnt == SCFC_LAST_BYTE) begin
            s_d.cnt = 3'h0;
          end
        end
      end
      SCFC_EXEC: begin
        // turnaround set by the executing logic
        if (i_exec_done) begin
          s_d.pkt  = {SCFC_HDR, s_q.id, s_q.cmd, i_resp_param_high_byte, i_resp_param_low_byte};
          s_d.load = 1'b1;
          s_d.cts  = 1'b1;
          s_d.st   = SCFC_RESP;
        end
      end
      SCFC_RESP: begin
        // rts low here is a pause, not a disconnect
        if (!s_q.load && !link.busy) begin
          s_d.st = SCFC_READY;
        end
      end
      default: begin
        s_d.st  = SCFC_IDLE;
        s_d.cts = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      s_q    <= '0;
      s_q.st <= SCFC_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************

  // outputs, all from flops
  assign o_cts                 = s_q.cts;
  assign o_tx_valid            = link.tx_valid;
  assign o_tx_data             = link.tx_data;
  assign o_cmd_valid           = s_q.cmd_valid;
  assign o_cmd_code            = s_q.cmd;
  assign o_cmd_param_high_byte = s_q.param_high;
  assign o_cmd_param_low_byte  = s_q.param_low;
  assign o_enter_special2      = s_q.special2;
  assign o_enter_service       = s_q.service;
  assign o_resp_aborted        = s_q.aborted;

endmodule
`default_nettype wire

// *** verif/scfc_top_sva.sv ***
// checker for the serial command flow-control block
// assumes it is bound into scfc_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module scfc_top_sva
  import scfc_pkg::*;
#(
  parameter int HOLD_CYCLES = SCFC_HOLD_CYCLES
) (
  // clock, reset and pins
  input wire logic       i_sys_clk,
  input wire logic       i_reset,
  input wire logic       i_rts,
  input wire logic       o_cts,
  input wire logic       o_tx_valid,
  input wire logic [7:0] o_tx_data,
  input wire logic       i_tx_ready,
  input wire logic       o_cmd_valid,
  input wire logic       o_enter_special2,
  input wire logic       o_enter_service,
  input wire logic       o_resp_aborted
);
  // ****************************************************************
  // rts low counter and assertions
  // ****************************************************************
  logic [31:0] low_cnt_q;

  // counts cycles of rts low, saturating
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || i_rts) begin
      low_cnt_q <= '0;
    end else if (~&low_cnt_q) begin
      low_cnt_q <= low_cnt_q + 32'h1;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  chk_cts_after_rts: assert property ($rose(i_rts) |-> ##[1:4] o_cts)
    else $error("cts late after rts rise");
  chk_mode_resp_start: assert property ((o_enter_service || o_enter_special2) |-> o_cts ##[1:2]
    (o_tx_valid && o_tx_data == SCFC_HDR)) else $error("mode entry response not started");
  chk_mode_one_hot: assert property (!(o_enter_service && o_enter_special2))
    else $error("both mode pulses at once");
  chk_exec_cts_low: assert property (o_cmd_valid |-> !o_cts)
    else $error("cts high on command accept");
  chk_tx_byte_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("offered byte withdrawn");
  chk_pause_stops_tx: assert property ((!i_rts)[*5] ##0 (o_tx_valid && i_tx_ready) |=> !o_tx_valid)
    else $error("byte offered while paused");
  chk_abort_hold_time: assert property (o_resp_aborted |-> low_cnt_q >= 32'(HOLD_CYCLES) && !o_tx_valid)
    else $error("abort before hold expiry");
  chk_rx_drop_low: assert property ((!i_rts)[*8] |-> !(o_cmd_valid || o_enter_service || o_enter_special2))
    else $error("packet taken with rts low");
endmodule

bind scfc_top scfc_top_sva #(.HOLD_CYCLES(HOLD_CYCLES)) chk (.i_sys_clk, .i_reset, .i_rts, .o_cts,
  .o_tx_valid, .o_tx_data, .i_tx_ready, .o_cmd_valid, .o_enter_special2, .o_enter_service, .o_resp_aborted);
`default_nettype wire

// *** verif/scfc_host_model.sv ***
// host model: drives rts and received bytes, takes transmitted bytes
// assumes the bench calls its tasks at rising clock edges
`timescale 1ns/1ps
`default_nettype none
module scfc_host_model (
  // clock and handshake
  input  wire logic       i_sys_clk,
  input  wire logic       i_cts,
  output logic            o_rts,
  // byte streams
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  output logic            o_tx_ready
);
  // ****************************************************************
  // uart pacing and packet tasks
  // ****************************************************************
  logic       slow  = 1'b0;
  logic [1:0] cnt_q = 2'h0;
  initial begin
    o_rts      = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h5A;
    o_tx_ready = 1'b0;
  end

  // takes a byte every cycle, or one in four when stalling
  always @(posedge i_sys_clk) begin
    cnt_q      <= cnt_q + 2'h1;
    o_tx_ready <= !slow || cnt_q == 2'h0;
  end

  // raise when ready, drop to pause a response
  task automatic set_rts(input logic v);
    o_rts <= v;
  endtask

  // five bytes back to back, once cts is seen or 1000 cycles pass when attached
  task automatic send(input logic [39:0] p);
    int i;
    for (i = 0; i < 1000 && o_rts && i_cts !== 1'b1; i++) @(negedge i_sys_clk);
    for (i = 0; i < 5; i++) begin
      @(posedge i_sys_clk);
      o_rx_valid <= 1'b1;
      o_rx_data  <= p[39 - 8 * i -: 8];
    end
    @(posedge i_sys_clk);
    o_rx_valid <= 1'b0;
    o_rx_data  <= ~p[7:0]; // idle line does not keep the last byte
  endtask
endmodule
`default_nettype wire

// *** verif/tb_serial_command_flow_control.sv ***
// self-checking bench for the serial command flow-control block
// assumes scfc_pkg, scfc_top, the checker and the host model
`timescale 1ns/1ps
`default_nettype none
module tb_serial_command_flow_control;
  import scfc_pkg::*;
  localparam int HOLD = 50;
  // ****************************************************************
  // signals, clock, models
  // ****************************************************************
  logic        sys_clk   = 1'b0;
  logic        reset     = 1'b1;
  logic        exec_done = 1'b0;
  logic [7:0]  device_id = 8'h00;
  logic [7:0]  resp_hi   = 8'h00;
  logic [7:0]  resp_lo   = 8'h00;
  logic [31:0] seed      = 32'hD000DEA7;
  wire logic   rts, rx_valid, tx_ready;
  wire logic [7:0] rx_data;
  logic        cts, tx_valid, cmd_valid, en_sp2, en_svc, aborted;
  logic [7:0]  tx_data, cmd_code, cmd_hi, cmd_lo;
  logic [7:0]  exp_q[$];
  logic [3:0]  ev_q[$];
  int          failures = 0;
  int          compares = 0;

  always #12.5 sys_clk = ~sys_clk;

  scfc_host_model host (.i_sys_clk(sys_clk), .i_cts(cts), .o_rts(rts), .o_rx_valid(rx_valid),
    .o_rx_data(rx_data), .o_tx_ready(tx_ready));
  scfc_top #(.HOLD_CYCLES(HOLD)) dut (.i_sys_clk(sys_clk), .i_reset(reset), .i_rts(rts), .o_cts(cts),
    .i_rx_valid(rx_valid), .i_rx_data(rx_data), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
    .i_tx_ready(tx_ready), .i_device_id(device_id), .o_cmd_valid(cmd_valid), .o_cmd_code(cmd_code),
    .o_cmd_param_high_byte(cmd_hi), .o_cmd_param_low_byte(cmd_lo), .i_exec_done(exec_done),
    .i_resp_param_high_byte(resp_hi), .i_resp_param_low_byte(resp_lo), .o_enter_special2(en_sp2),
    .o_enter_service(en_svc), .o_resp_aborted(aborted));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp8(input logic [7:0] e, input logic [7:0] a);
    compares++;
    if (a !== e) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask

  task automatic cmp4(input logic [3:0] e, input logic [3:0] a);
    compares++;
    if (a !== e) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 400 && (exp_q.size() != 0 || cts !== 1'b1); i++) @(negedge sys_clk);
    repeat (4) @(posedge sys_clk);
  endtask

  // mode entry with any id, optionally paused for hold cycles mid-response
  task automatic mode(input logic [7:0] param_low_byte, input logic [3:0] ev, input int hold);
    int i;
    logic [7:0] idv;
    idv = 8'(rnd());
    ev_q.push_back(ev);
    if (hold > HOLD) ev_q.push_back(4'h8);
    exp_q = {exp_q, SCFC_HDR, idv, SCFC_CMD_MODE, SCFC_RESP_ZERO, SCFC_RESP_ZERO};
    host.send({SCFC_HDR, idv, SCFC_CMD_MODE, SCFC_PH_MODE, param_low_byte});
    if (hold > 0) begin
      for (i = 0; i < 50 && tx_valid !== 1'b1; i++) @(negedge sys_clk);
      @(posedge sys_clk);
      host.set_rts(1'b0);
      repeat (hold) @(posedge sys_clk);
      host.set_rts(1'b1);
    end
    wait_idle();
  endtask

  // ordinary command; a foreign id gets no answer
  task automatic ordinary(input logic [7:0] code, input logic match);
    int i;
    logic [7:0] h, l, idv;
    h   = 8'(rnd());
    l   = 8'(rnd());
    idv = match ? device_id : ~device_id;
    if (match) begin
      ev_q.push_back(4'h4);
      exp_q = {exp_q, SCFC_HDR, idv, code, h, l};
    end
    host.send({SCFC_HDR, idv, code, h, l});
    if (match) begin
      for (i = 0; i < 20 && cmd_valid !== 1'b1; i++) @(negedge sys_clk);
      cmp8(code, cmd_code);
      cmp8(h, cmd_hi);
      cmp8(l, cmd_lo);
      repeat (2 + rnd() % 6) @(posedge sys_clk);
      cmp8(8'h00, {7'h0, cts});
      exec_done <= 1'b1;
      resp_hi   <= h;
      resp_lo   <= l;
      @(posedge sys_clk);
      exec_done <= 1'b0;
    end
    wait_idle();
  endtask

  task automatic print_verdict();
    failures += exp_q.size() + ev_q.size();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ****************************************************************
  // monitor, watchdog, sequence
  // ****************************************************************
  // takes the oldest note for each byte or pulse seen
  always @(posedge sys_clk) begin
    if (!reset && tx_valid && tx_ready) cmp8(exp_q.size() ? exp_q.pop_front() : 8'hXX, tx_data);
    if (!reset && (aborted || cmd_valid || en_sp2 || en_svc)) begin
      cmp4(ev_q.size() ? ev_q.pop_front() : 4'hX, {aborted, cmd_valid, en_sp2, en_svc});
      if (aborted) exp_q.delete();
    end
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    device_id <= 8'(rnd());
    reset     <= 1'b0;
    host.set_rts(1'b1);
    repeat (5) @(posedge sys_clk);
    cmp8(8'h01, {7'h0, cts});
    mode(SCFC_PL_SPECIAL2, 4'h2, 0);
    mode(SCFC_PL_SERVICE, 4'h1, 0);
    ordinary(8'(rnd()) & 8'h7F, 1'b1);
    ordinary(8'h12, 1'b0);
    host.slow <= 1'b1;
    mode(SCFC_PL_SERVICE, 4'h1, 20);
    mode(SCFC_PL_SPECIAL2, 4'h2, HOLD + 30);
    host.slow <= 1'b0;
    host.set_rts(1'b0);
    repeat (6) @(posedge sys_clk);
    host.send({SCFC_HDR, device_id, SCFC_CMD_MODE, SCFC_PH_MODE, SCFC_PL_SERVICE});
    host.set_rts(1'b1);
    wait_idle();
    print_verdict();
  end
endmodule
`default_nettype wire
